// [rtl/spia_assign.sv]
`timescale 1ns/1ps
module spia_assign
  import spia_pkg::*;
#(
  parameter int AW = 48,
  parameter int PID_W = 16,
  parameter int GRP_W = 8,
  parameter int SEL_W = 1,
  parameter bit PART_PRESENT = 1'b1,
  parameter logic [15:0] MAX_PID_NS = 16'h001f,
  parameter logic [7:0] MAX_GRP_NS = 8'h03,
  parameter logic [15:0] MAX_PID_S = 16'h000f,
  parameter logic [7:0] MAX_GRP_S = 8'h01
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic up_valid,
  input wire logic [AW-1:0] up_addr,
  input wire logic up_secure_stream_flag,
  input wire logic up_has_substream,
  input wire logic [PID_W-1:0] up_client_partition_identifier,
  input wire logic [GRP_W-1:0] up_client_monitoring_group,
  input wire logic [2:0] entry_config,
  input wire logic entry_stage1_partition_control,
  input wire logic [1:0] entry_stage1_default_substream,
  input wire logic [PID_W-1:0] entry_partition_identifier,
  input wire logic [GRP_W-1:0] entry_monitoring_group,
  input wire logic [SEL_W-1:0] entry_vm_structure_pointer,
  input wire logic [PID_W-1:0] desc_partition_identifier,
  input wire logic [GRP_W-1:0] desc_monitoring_group,
  output logic dn_valid,
  output logic [AW-1:0] dn_addr,
  output logic [PID_W-1:0] dn_partition_identifier,
  output logic [GRP_W-1:0] dn_monitoring_group,
  output logic dn_nonsecure_partition_flag,
  output logic dn_map_used,
  output logic [PID_W-1:0] glb_partition_identifier_ns,
  output logic [GRP_W-1:0] glb_monitoring_group_ns,
  output logic [PID_W-1:0] glb_partition_identifier_s,
  output logic [GRP_W-1:0] glb_monitoring_group_s
);
  localparam int IDX_W = SEL_W + VPART_W;

  typedef struct packed {
    logic en_ns;
    logic en_s;
    logic [PID_W-1:0] byp_pid_ns;
    logic [GRP_W-1:0] byp_grp_ns;
    logic [PID_W-1:0] byp_pid_s;
    logic [GRP_W-1:0] byp_grp_s;
    logic [PID_W-1:0] glb_pid_ns;
    logic [GRP_W-1:0] glb_grp_ns;
    logic [PID_W-1:0] glb_pid_s;
    logic [GRP_W-1:0] glb_grp_s;
    logic [IDX_W-1:0] map_idx;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic dn_valid;
    logic [AW-1:0] dn_addr;
    logic [PID_W-1:0] dn_pid;
    logic [GRP_W-1:0] dn_grp;
    logic dn_ns;
    logic dn_map;
  } spia_state_t;

  spia_state_t q, d;

  logic acc_setup;
  logic acc_commit;
  logic wr_commit;
  logic hit;
  logic [31:0] rd_val;
  logic sup_ns;
  logic sup_s;
  logic req_sup;
  logic req_en;
  logic req_struct_ok;
  logic [2:0] cfg_eff;
  logic [PID_W-1:0] sel_pid;
  logic [GRP_W-1:0] sel_grp;
  logic sel_map;
  logic map_we;
  logic [PID_W-1:0] map_lk_data;
  logic [PID_W-1:0] map_sw_data;
  logic [IDX_W-1:0] map_lk_idx;

  // one wait state: pready rises one cycle into the access phase
  assign acc_setup = psel & penable & ~q.pready;
  assign acc_commit = psel & penable & q.pready;
  assign wr_commit = acc_commit & pwrite;
  assign map_we = wr_commit & (paddr == OFS_MAP_DATA);

  assign sup_ns = PART_PRESENT && ((MAX_PID_NS != '0) || (MAX_GRP_NS != '0));
  assign sup_s = PART_PRESENT && ((MAX_PID_S != '0) || (MAX_GRP_S != '0));
  assign req_sup = up_secure_stream_flag ? sup_s : sup_ns;
  assign req_en = up_secure_stream_flag ? q.en_s : q.en_ns;
  // a zero partition maximum means no map structure exists for that state
  assign req_struct_ok = up_secure_stream_flag ? (MAX_PID_S != '0) : (MAX_PID_NS != '0);
  assign map_lk_idx = {entry_vm_structure_pointer, desc_partition_identifier[VPART_W-1:0]};

  always_comb begin
    cfg_eff = entry_config;
    if (entry_config == CFG_NESTED && entry_stage1_default_substream == DSS_NOSS_S2
        && !up_has_substream) begin
      cfg_eff = CFG_S2;
    end
  end

  // client-supplied identifier inputs are deliberately never read
  always_comb begin
    sel_pid = '0;
    sel_grp = '0;
    sel_map = 1'b0;
    if (!req_sup) begin
      sel_pid = '0;
      sel_grp = '0;
    end else if (!req_en) begin
      sel_pid = up_secure_stream_flag ? q.byp_pid_s : q.byp_pid_ns;
      sel_grp = up_secure_stream_flag ? q.byp_grp_s : q.byp_grp_ns;
    end else begin
      sel_pid = entry_partition_identifier;
      sel_grp = entry_monitoring_group;
      unique case (cfg_eff)
        CFG_S1: begin
          if (entry_stage1_partition_control) begin
            sel_pid = desc_partition_identifier;
            sel_grp = desc_monitoring_group;
          end
        end
        CFG_NESTED: begin
          if (entry_stage1_partition_control && req_struct_ok) begin
            sel_pid = map_lk_data;
            sel_grp = desc_monitoring_group;
            sel_map = 1'b1;
          end
        end
        default: begin
          sel_pid = entry_partition_identifier;
          sel_grp = entry_monitoring_group;
        end
      endcase
    end
  end

  always_comb begin
    hit = 1'b1;
    rd_val = RST_WORD;
    unique case (paddr)
      OFS_IDENT: rd_val[IDENT_PART_BIT] = PART_PRESENT;
      OFS_CTRL_NS: rd_val[CTRL_EN_BIT] = q.en_ns;
      OFS_CTRL_S: rd_val[CTRL_EN_BIT] = q.en_s;
      OFS_CAP_NS: begin
        if (PART_PRESENT) begin
          rd_val[FLD_PID_LSB +: 16] = MAX_PID_NS;
          rd_val[FLD_GRP_LSB +: 8] = MAX_GRP_NS;
        end
      end
      OFS_CAP_S: begin
        if (PART_PRESENT) begin
          rd_val[FLD_PID_LSB +: 16] = MAX_PID_S;
          rd_val[FLD_GRP_LSB +: 8] = MAX_GRP_S;
        end
      end
      OFS_BYP_NS: begin
        rd_val[FLD_PID_LSB +: PID_W] = q.byp_pid_ns;
        rd_val[FLD_GRP_LSB +: GRP_W] = q.byp_grp_ns;
      end
      OFS_BYP_S: begin
        rd_val[FLD_PID_LSB +: PID_W] = q.byp_pid_s;
        rd_val[FLD_GRP_LSB +: GRP_W] = q.byp_grp_s;
      end
      OFS_GLB_NS: begin
        rd_val[FLD_PID_LSB +: PID_W] = q.glb_pid_ns;
        rd_val[FLD_GRP_LSB +: GRP_W] = q.glb_grp_ns;
      end
      OFS_GLB_S: begin
        rd_val[FLD_PID_LSB +: PID_W] = q.glb_pid_s;
        rd_val[FLD_GRP_LSB +: GRP_W] = q.glb_grp_s;
      end
      OFS_MAP_IDX: rd_val[IDX_W-1:0] = q.map_idx;
      OFS_MAP_DATA: rd_val[PID_W-1:0] = map_sw_data;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    d.pready = acc_setup;
    d.pslverr = acc_setup & ~hit;
    d.prdata = (acc_setup && !pwrite && hit) ? rd_val : RST_WORD;
    if (wr_commit) begin
      unique case (paddr)
        OFS_CTRL_NS: d.en_ns = pwdata[CTRL_EN_BIT];
        OFS_CTRL_S: d.en_s = pwdata[CTRL_EN_BIT];
        OFS_BYP_NS: begin
          d.byp_pid_ns = pwdata[FLD_PID_LSB +: PID_W];
          d.byp_grp_ns = pwdata[FLD_GRP_LSB +: GRP_W];
        end
        OFS_BYP_S: begin
          d.byp_pid_s = pwdata[FLD_PID_LSB +: PID_W];
          d.byp_grp_s = pwdata[FLD_GRP_LSB +: GRP_W];
        end
        OFS_GLB_NS: begin
          d.glb_pid_ns = pwdata[FLD_PID_LSB +: PID_W];
          d.glb_grp_ns = pwdata[FLD_GRP_LSB +: GRP_W];
        end
        OFS_GLB_S: begin
          d.glb_pid_s = pwdata[FLD_PID_LSB +: PID_W];
          d.glb_grp_s = pwdata[FLD_GRP_LSB +: GRP_W];
        end
        OFS_MAP_IDX: d.map_idx = pwdata[IDX_W-1:0];
        default: d.en_ns = q.en_ns;
      endcase
    end
    d.dn_valid = up_valid;
    if (up_valid) begin
      d.dn_addr = up_addr;
      d.dn_pid = sel_pid;
      d.dn_grp = sel_grp;
      d.dn_ns = ~up_secure_stream_flag;
      d.dn_map = sel_map;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  spia_map_store #(
    .IDX_W(IDX_W),
    .DW(PID_W)
  ) u_map (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(map_we),
    .wr_idx(q.map_idx),
    .wr_data(pwdata[PID_W-1:0]),
    .lk_idx(map_lk_idx),
    .lk_data(map_lk_data),
    .sw_idx(q.map_idx),
    .sw_data(map_sw_data)
  );

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign dn_valid = q.dn_valid;
  assign dn_addr = q.dn_addr;
  assign dn_partition_identifier = q.dn_pid;
  assign dn_monitoring_group = q.dn_grp;
  assign dn_nonsecure_partition_flag = q.dn_ns;
  assign dn_map_used = q.dn_map;
  assign glb_partition_identifier_ns = q.glb_pid_ns;
  assign glb_monitoring_group_ns = q.glb_grp_ns;
  assign glb_partition_identifier_s = q.glb_pid_s;
  assign glb_monitoring_group_s = q.glb_grp_s;

  property p_ns_flag;
    @(posedge pclk) disable iff (!presetn)
      up_valid |=> dn_valid && (dn_nonsecure_partition_flag == !$past(up_secure_stream_flag));
  endproperty
  a_ns_flag: assert property (p_ns_flag) else $error("non-secure flag wrong");

  property p_unsup;
    @(posedge pclk) disable iff (!presetn)
      up_valid && !req_sup |=> dn_partition_identifier == '0 && dn_monitoring_group == '0;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported state got ids");

  property p_bypass;
    @(posedge pclk) disable iff (!presetn)
      up_valid && req_sup && !req_en && !up_secure_stream_flag
      |=> dn_partition_identifier == $past(q.byp_pid_ns) && !dn_map_used;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass id wrong");

  property p_ste_cfg;
    @(posedge pclk) disable iff (!presetn)
      up_valid && req_sup && req_en && (cfg_eff == CFG_BYPASS || cfg_eff == CFG_S2)
      |=> dn_partition_identifier == $past(entry_partition_identifier)
          && dn_monitoring_group == $past(entry_monitoring_group);
  endproperty
  a_ste_cfg: assert property (p_ste_cfg) else $error("entry ids not used");

  property p_s1_cd;
    @(posedge pclk) disable iff (!presetn)
      up_valid && req_sup && req_en && entry_config == CFG_S1 && entry_stage1_partition_control
      |=> dn_partition_identifier == $past(desc_partition_identifier);
  endproperty
  a_s1_cd: assert property (p_s1_cd) else $error("descriptor id not used");

  property p_nested_map;
    @(posedge pclk) disable iff (!presetn)
      up_valid && req_sup && req_en && cfg_eff == CFG_NESTED
      && entry_stage1_partition_control && req_struct_ok
      |=> dn_map_used && dn_partition_identifier == $past(map_lk_data)
          && dn_monitoring_group == $past(desc_monitoring_group);
  endproperty
  a_nested_map: assert property (p_nested_map) else $error("nested map not applied");

  property p_no_map;
    @(posedge pclk) disable iff (!presetn)
      up_valid && (entry_config != CFG_NESTED || !entry_stage1_partition_control)
      |=> !dn_map_used;
  endproperty
  a_no_map: assert property (p_no_map) else $error("map used wrongly");

  property p_stage1_default_substream;
    @(posedge pclk) disable iff (!presetn)
      up_valid && req_sup && req_en && entry_config == CFG_NESTED && !up_has_substream
      && entry_stage1_default_substream == DSS_NOSS_S2
      |=> !dn_map_used && dn_partition_identifier == $past(entry_partition_identifier);
  endproperty
  a_stage1_default_substream: assert property (p_stage1_default_substream) else $error("no-substream rule broken");

  property p_no_struct;
    @(posedge pclk) disable iff (!presetn)
      up_valid && !req_struct_ok |=> !dn_map_used;
  endproperty
  a_no_struct: assert property (p_no_struct) else $error("map used without structure");

  property p_glb;
    @(posedge pclk) disable iff (!presetn)
      wr_commit && paddr == OFS_GLB_S
      |=> glb_partition_identifier_s == $past(pwdata[PID_W-1:0]);
  endproperty
  a_glb: assert property (p_glb) else $error("global config not stored");
endmodule : spia_assign

// [rtl/spia_map_store.sv]
`timescale 1ns/1ps
module spia_map_store #(
  parameter int IDX_W = 6,
  parameter int DW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [DW-1:0] wr_data,
  input wire logic [IDX_W-1:0] lk_idx,
  output logic [DW-1:0] lk_data,
  input wire logic [IDX_W-1:0] sw_idx,
  output logic [DW-1:0] sw_data
);
  localparam int ENTRIES = 1 << IDX_W;
  typedef struct packed {
    logic [ENTRIES-1:0][DW-1:0] ent;
  } spia_map_state_t;
  spia_map_state_t map_q, map_d;

  always_comb begin
    map_d = map_q;
    if (wr_en) begin
      map_d.ent[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_q <= '0;
    end else begin
      map_q <= map_d;
    end
  end

  // read ports are combinational; the top registers the looked-up value
  assign lk_data = map_q.ent[lk_idx];
  assign sw_data = map_q.ent[sw_idx];
endmodule : spia_map_store

// [rtl/spia_pkg.sv]
package spia_pkg;
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_CTRL_NS = 8'h04;
  localparam logic [7:0] OFS_CTRL_S = 8'h08;
  localparam logic [7:0] OFS_CAP_NS = 8'h0c;
  localparam logic [7:0] OFS_CAP_S = 8'h10;
  localparam logic [7:0] OFS_BYP_NS = 8'h14;
  localparam logic [7:0] OFS_BYP_S = 8'h18;
  localparam logic [7:0] OFS_GLB_NS = 8'h1c;
  localparam logic [7:0] OFS_GLB_S = 8'h20;
  localparam logic [7:0] OFS_MAP_IDX = 8'h24;
  localparam logic [7:0] OFS_MAP_DATA = 8'h28;
  localparam int IDENT_PART_BIT = 0;
  localparam int CTRL_EN_BIT = 0;
  localparam int FLD_PID_LSB = 0;
  localparam int FLD_GRP_LSB = 16;
  localparam int VPART_W = 5;
  localparam logic [2:0] CFG_BYPASS = 3'b100;
  localparam logic [2:0] CFG_S1 = 3'b101;
  localparam logic [2:0] CFG_S2 = 3'b110;
  localparam logic [2:0] CFG_NESTED = 3'b111;
  localparam logic [1:0] DSS_NOSS_S2 = 2'b01;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : spia_pkg

// [testbench/spia_sink_model.sv]
`timescale 1ns/1ps
module spia_sink_model #(
  parameter int AW = 48
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dn_valid,
  input wire logic [AW-1:0] dn_addr,
  input wire logic [15:0] dn_partition_identifier,
  input wire logic [7:0] dn_monitoring_group,
  input wire logic dn_nonsecure_partition_flag,
  input wire logic dn_map_used,
  output logic [AW-1:0] cap_addr,
  output logic [15:0] cap_pid,
  output logic [7:0] cap_grp,
  output logic cap_ns,
  output logic cap_map,
  output int beats
);
  // interconnect side takes every beat; the block has no backpressure to exercise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beats <= 0;
      cap_addr <= '0;
      cap_pid <= '0;
      cap_grp <= '0;
      cap_ns <= 1'b0;
      cap_map <= 1'b0;
    end else if (dn_valid) begin
      beats <= beats + 1;
      cap_addr <= dn_addr;
      cap_pid <= dn_partition_identifier;
      cap_grp <= dn_monitoring_group;
      cap_ns <= dn_nonsecure_partition_flag;
      cap_map <= dn_map_used;
    end
  end
endmodule : spia_sink_model

// [testbench/stream_partition_id_assign_tb.sv]
`timescale 1ns/1ps
module stream_partition_id_assign_tb;
  import spia_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic up_valid, up_secure_stream_flag, up_has_substream, entry_stage1_partition_control;
  logic [47:0] up_addr, dn_addr, cap_addr;
  logic [15:0] up_client_partition_identifier, entry_partition_identifier;
  logic [15:0] desc_partition_identifier;
  logic [7:0] up_client_monitoring_group, entry_monitoring_group, desc_monitoring_group;
  logic [2:0] entry_config;
  logic [1:0] entry_stage1_default_substream;
  logic [0:0] entry_vm_structure_pointer;
  logic dn_valid, dn_nonsecure_partition_flag, dn_map_used, cap_ns, cap_map;
  logic [15:0] dn_partition_identifier, glb_partition_identifier_ns, glb_partition_identifier_s;
  logic [7:0] dn_monitoring_group, glb_monitoring_group_ns, glb_monitoring_group_s, cap_grp;
  logic [15:0] cap_pid;
  int err_count = 0;
  int compares = 0;
  int beats, b0;
  int tsrc [8] = '{0, 0, 0, 1, 0, 2, 0, 2};
  logic [2:0] tcfg [8] = '{CFG_BYPASS, CFG_S2, CFG_S1, CFG_S1, CFG_NESTED, CFG_NESTED,
                           CFG_NESTED, CFG_NESTED};
  logic [7:0] tctl = 8'heb;
  logic [7:0] tsub = 8'hbc;

  spia_assign spia_assign_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .up_valid, .up_addr, .up_secure_stream_flag, .up_has_substream,
    .up_client_partition_identifier, .up_client_monitoring_group, .entry_config,
    .entry_stage1_partition_control, .entry_stage1_default_substream,
    .entry_partition_identifier, .entry_monitoring_group, .entry_vm_structure_pointer,
    .desc_partition_identifier, .desc_monitoring_group,
    .dn_valid, .dn_addr, .dn_partition_identifier, .dn_monitoring_group,
    .dn_nonsecure_partition_flag, .dn_map_used, .glb_partition_identifier_ns,
    .glb_monitoring_group_ns, .glb_partition_identifier_s, .glb_monitoring_group_s);

  spia_sink_model spia_sink_model_inst (.pclk, .presetn, .dn_valid, .dn_addr,
    .dn_partition_identifier, .dn_monitoring_group, .dn_nonsecure_partition_flag, .dn_map_used,
    .cap_addr, .cap_pid, .cap_grp, .cap_ns, .cap_map, .beats);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // master waits on pready without assuming a latency; the watchdog ends a stuck wait
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(logic [7:0] a, logic [31:0] exp, logic e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk(err, e);
  endtask : rdc

  task automatic send(logic sec, logic sub, logic [2:0] cfg, logic ctl, logic [1:0] dss);
    b0 = beats;
    @(posedge pclk);
    up_valid <= 1'b1;
    up_secure_stream_flag <= sec;
    up_has_substream <= sub;
    entry_config <= cfg;
    entry_stage1_partition_control <= ctl;
    entry_stage1_default_substream <= dss;
    up_addr <= up_addr + 48'h1000;
    @(posedge pclk);
    up_valid <= 1'b0;
    @(posedge pclk);
    #1;
    chk(beats - b0, 1);
    chk(dn_valid, 1'b0);
    chk(cap_addr, up_addr);
  endtask : send

  task automatic ids(logic [15:0] pid, logic [7:0] grp, logic ns, logic map);
    chk(cap_pid, pid);
    chk(cap_grp, grp);
    chk(cap_ns, ns);
    chk(cap_map, map);
  endtask : ids

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    complete_run();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, up_valid, up_secure_stream_flag, up_has_substream} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    up_addr = 48'h0000_0000_0000;
    entry_config = CFG_BYPASS;
    entry_stage1_partition_control = 1'b0;
    entry_stage1_default_substream = 2'b00;
    // client-supplied values must never leak through
    up_client_partition_identifier = 16'hbeef;
    up_client_monitoring_group = 8'hee;
    entry_partition_identifier = 16'h0123;
    entry_monitoring_group = 8'h45;
    desc_partition_identifier = 16'h0a03;
    desc_monitoring_group = 8'h66;
    entry_vm_structure_pointer = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk({dn_valid, dn_partition_identifier, glb_partition_identifier_ns}, '0);
    rdc(OFS_IDENT, 32'h0000_0001, 1'b0);
    apb(1'b1, OFS_IDENT, 32'h0000_0000);
    rdc(OFS_IDENT, 32'h0000_0001, 1'b0);
    rdc(OFS_CAP_NS, 32'h0003_001f, 1'b0);
    rdc(OFS_CAP_S, 32'h0001_000f, 1'b0);
    rdc(8'h40, 32'h0000_0000, 1'b1);
    $display("test discovery done");
    apb(1'b1, OFS_BYP_NS, 32'h0005_0011);
    apb(1'b1, OFS_BYP_S, 32'h0002_0007);
    rdc(OFS_BYP_NS, 32'h0005_0011, 1'b0);
    send(1'b0, 1'b0, CFG_S1, 1'b1, 2'b00);
    ids(16'h0011, 8'h05, 1'b1, 1'b0);
    send(1'b1, 1'b0, CFG_S1, 1'b1, 2'b00);
    ids(16'h0007, 8'h02, 1'b0, 1'b0);
    $display("test bypass done");
    apb(1'b1, OFS_CTRL_NS, 32'h0000_0001);
    apb(1'b1, OFS_MAP_IDX, 32'h0000_0023);
    apb(1'b1, OFS_MAP_DATA, 32'h0000_0777);
    rdc(OFS_MAP_DATA, 32'h0000_0777, 1'b0);
    for (int i = 0; i < 8; i++) begin
      send(1'b0, tsub[i], tcfg[i], tctl[i], (i >= 6) ? DSS_NOSS_S2 : 2'b00);
      case (tsrc[i])
        0: ids(16'h0123, 8'h45, 1'b1, 1'b0);
        1: ids(16'h0a03, 8'h66, 1'b1, 1'b0);
        default: ids(16'h0777, 8'h66, 1'b1, 1'b1);
      endcase
    end
    $display("test stream entry done");
    b0 = beats;
    @(posedge pclk);
    up_valid <= 1'b1;
    up_secure_stream_flag <= 1'b0;
    @(posedge pclk);
    up_secure_stream_flag <= 1'b1;
    @(posedge pclk);
    up_valid <= 1'b0;
    @(posedge pclk);
    #1;
    chk(beats - b0, 2);
    chk(cap_ns, 1'b0);
    $display("test back to back done");
    apb(1'b1, OFS_GLB_NS, 32'h0012_0034);
    apb(1'b1, OFS_GLB_S, 32'h0009_000a);
    #1;
    chk({glb_monitoring_group_ns, glb_partition_identifier_ns}, 24'h12_0034);
    chk({glb_monitoring_group_s, glb_partition_identifier_s}, 24'h09_000a);
    rdc(OFS_GLB_S, 32'h0009_000a, 1'b0);
    $display("test global done");
    complete_run();
  end
endmodule : stream_partition_id_assign_tb
